//--- inc/rcf_pkg.sv
// Shared constants and carrier types for the RAM coefficient decimating filter.
package rcf_pkg;
  // ==========================================================================
  // Widths
  localparam int DATA_W = 18;
  localparam int COEF_W = 20;
  localparam int RAM_AW = 8;
  localparam int CNT_W = 9;
  localparam int PROD_W = DATA_W + COEF_W;
  localparam int ACC_W = PROD_W + 3;
  localparam int RES_W = 23;
  localparam int RES_LSB = ACC_W - RES_W;
  localparam int OUT_W = 16;
  localparam int WORD_W = 24;
  localparam int CTL_AW = 10;
  localparam int CTL_DW = 2 * DATA_W;
  localparam int SCALE_W = 3;
  localparam int DEC_W = 5;
  localparam int WIDE_W = 31;

  // ==========================================================================
  // Internal address map
  localparam logic [1:0] PAGE_COEF = 2'h0;
  localparam logic [1:0] PAGE_DATA = 2'h1;
  localparam logic [9:0] ADDR_MODE = 10'h300;
  localparam logic [9:0] ADDR_SCALE = 10'h309;
  localparam logic [9:0] ADDR_RATIO = 10'h30a;
  localparam logic [9:0] ADDR_OFFSET = 10'h30b;
  localparam logic [9:0] ADDR_TAPS = 10'h30c;

  // ==========================================================================
  // Field positions and reset values
  localparam int MODE_SOFT_RESET = 0;
  localparam int MODE_DIVERSITY = 1;
  localparam int SCALE_UNIQUE_B = 3;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] SCALE_RESET = 8'h04;
  localparam logic [7:0] RATIO_RESET = 8'h00;
  localparam logic [7:0] OFFSET_RESET = 8'h00;
  localparam logic [7:0] TAPS_RESET = 8'h00;

  // ==========================================================================
  // Output scaling: unity gain at scale value 4, 16 of 23 bits kept.
  localparam int UNITY_SHIFT = 4;
  localparam int ROUND_SHIFT = RES_W - OUT_W;
  localparam logic signed [WIDE_W-1:0] ROUND_HALF = 31'sh40;
  localparam logic signed [WIDE_W-1:0] SAT_MAX = 31'sh7fff;
  localparam logic signed [WIDE_W-1:0] SAT_MIN = -31'sh8000;

  typedef struct packed {
    logic signed [DATA_W-1:0] i;
    logic signed [DATA_W-1:0] q;
  } rcf_sample_t;

  typedef struct packed {
    logic [CTL_AW-1:0] addr;
    logic wr;
    logic rd;
    logic [CTL_DW-1:0] wdata;
  } rcf_ctl_req_t;

  typedef struct packed {
    logic valid;
    logic chan_b;
    logic signed [WORD_W-1:0] i;
    logic signed [WORD_W-1:0] q;
  } rcf_out_t;
endpackage

//--- logic/rcf_ram.sv
// Single-port-write, registered-read memory used for coefficients and samples.
module rcf_ram #(
  parameter int WIDTH = 36,
  parameter int AW = 8
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [2**AW];

  // Contents are not reset; software clears the used data area at start-up.
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule

//--- logic/rcf_scale.sv
// Output word former: 23-bit result scaled and rounded to 16 bits, or passed wide.
module rcf_scale
  import rcf_pkg::*;
(
  input wire logic signed [rcf_pkg::RES_W-1:0] result,
  input wire logic [rcf_pkg::SCALE_W-1:0] scale,
  input wire logic wide_word,
  output logic signed [rcf_pkg::WORD_W-1:0] word
);
  logic signed [WIDE_W-1:0] ext;
  logic signed [WIDE_W-1:0] shifted;
  logic signed [WIDE_W-1:0] rounded;

  always_comb begin
    ext = WIDE_W'(result);
    shifted = (ext <<< UNITY_SHIFT) >>> scale;
    rounded = (shifted + ROUND_HALF) >>> ROUND_SHIFT;
    if (wide_word) begin
      word = WORD_W'(result);
    end else if (rounded > SAT_MAX) begin
      word = WORD_W'(SAT_MAX);
    end else if (rounded < SAT_MIN) begin
      word = WORD_W'(SAT_MIN);
    end else begin
      word = WORD_W'(rounded);
    end
  end
endmodule

//--- logic/rcf_fir.sv
// Decimating sum-of-products filter with RAM coefficients and circular data RAM.
// ============================================================================
// Summary of operation
// - Keep the wlen newest complex samples (up to 256), I and Q each at 18 bits.
// - Coefficient memory holds up to 256 coefficients of 20 bits.
// - Each cycle compute one I and one Q tap with one shared coefficient.
// - Accumulators carry three headroom bits; results carry 23 significant bits.
// - Decimate by any integer 1 to 32, one output per that many inputs.
// - Coefficients sit at 0x000 to 0x0FF as 20-bit two's complement values.
// - Lower coefficient addresses meet older samples; any length, any symmetry.
// - Samples live in a 256 by 36 memory used as a circular buffer.
// - Data area from 0x100 spans taps times channels, rounded up to even.
// - Output starts with oldest sample times coefficient at offset, then newer.
// - Outputs come at input sample rate divided by decimation ratio.
// - Sixteen-bit words are result times two to (4 minus scale), rounded.
// - Twenty-four bit words ignore the scale value.
// - Scale 4 is unity; each step down doubles, each step up halves.
// - Unique-B bit 3 of 309h gives channel B its own coefficient set.
// - Without unique-B index steps per A/B pair, with it per channel.
// - Diversity real mode, bit 1 of mode register 300, doubles channels.
module rcf_fir
  import rcf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic in_chan_b,
  input wire rcf_pkg::rcf_sample_t in_sample,
  input wire rcf_pkg::rcf_ctl_req_t ctl_req,
  input wire logic wide_word,
  output logic [rcf_pkg::CTL_DW-1:0] ctl_rdata,
  output logic ctl_rvalid,
  output logic engine_busy,
  output rcf_pkg::rcf_out_t out
);
  import rcf_pkg::*;

  // All state outside the two memories lives in one record, so a single process registers it.
  typedef struct packed {
    // Configuration registers.
    logic [7:0] mode;
    logic [7:0] scale;
    logic [7:0] final_decimation_ratio;
    logic [7:0] coefficient_start_offset;
    logic [7:0] taps_m1;

    // Sample buffer and decimation.
    logic [RAM_AW-1:0] wptr;
    logic [DEC_W-1:0] dec_cnt;

    // Tap engine and its one-stage read pipeline.
    logic busy;
    logic [CNT_W-1:0] step;
    logic [CNT_W-1:0] base;
    logic p_valid;
    logic p_ch;
    logic p_first;
    logic p_last;

    // Accumulators for the A and B channels.
    logic signed [ACC_W-1:0] acc_ai;
    logic signed [ACC_W-1:0] acc_aq;
    logic signed [ACC_W-1:0] acc_bi;
    logic signed [ACC_W-1:0] acc_bq;

    // Output staging.
    logic out_pend;
    logic b_pend;
    rcf_out_t out;

    // Host read answer.
    logic rd_pend;
    logic [CTL_AW-1:0] rd_addr;
    logic [CTL_DW-1:0] rdata;
    logic rvalid;
  } rcf_state_t;

  rcf_state_t st_r;
  rcf_state_t st_nxt;

  // ==========================================================================
  // Memories
  // The coefficient memory is written only by the host; the host writes the data memory
  // in any cycle without a sample, since a sample always takes the write port.
  logic coef_we;
  logic data_we;
  logic [RAM_AW-1:0] coef_waddr;
  logic [RAM_AW-1:0] data_waddr;
  logic [COEF_W-1:0] coef_wdata;
  rcf_sample_t data_wdata;
  logic [RAM_AW-1:0] coef_raddr;
  logic [RAM_AW-1:0] data_raddr;
  logic [COEF_W-1:0] coef_q;
  rcf_sample_t data_q;

  rcf_ram #(.WIDTH(COEF_W), .AW(RAM_AW)) u_coef_ram (
    .core_clk(core_clk),
    .wr_en(coef_we),
    .wr_addr(coef_waddr),
    .wr_data(coef_wdata),
    .rd_addr(coef_raddr),
    .rd_data(coef_q)
  );

  rcf_ram #(.WIDTH(CTL_DW), .AW(RAM_AW)) u_data_ram (
    .core_clk(core_clk),
    .wr_en(data_we),
    .wr_addr(data_waddr),
    .wr_data(data_wdata),
    .rd_addr(data_raddr),
    .rd_data(data_q)
  );

  // ==========================================================================
  // Output scaling
  // Both channels share the scale field; the wide word choice bypasses it.
  logic signed [RES_W-1:0] sc_in_i;
  logic signed [RES_W-1:0] sc_in_q;
  logic signed [WORD_W-1:0] sc_out_i;
  logic signed [WORD_W-1:0] sc_out_q;

  rcf_scale u_scale_i (
    .result(sc_in_i),
    .scale(st_r.scale[SCALE_W-1:0]),
    .wide_word(wide_word),
    .word(sc_out_i)
  );

  rcf_scale u_scale_q (
    .result(sc_in_q),
    .scale(st_r.scale[SCALE_W-1:0]),
    .wide_word(wide_word),
    .word(sc_out_q)
  );

  // ==========================================================================
  // Next-state logic
  logic diversity;
  logic unique_b;
  logic [CNT_W-1:0] taps;
  logic [CNT_W-1:0] len;
  logic [CNT_W-1:0] wlen;
  logic [CNT_W-1:0] wp_inc;
  logic [RAM_AW-1:0] wptr_new;
  logic [CNT_W:0] base_sum;
  logic [CNT_W:0] dsum;
  logic count_ev;
  logic trig;
  logic host_ram_rd;
  logic signed [PROD_W-1:0] prod_i;
  logic signed [PROD_W-1:0] prod_q;
  logic signed [ACC_W-1:0] add_i;
  logic signed [ACC_W-1:0] add_q;

  always_comb begin
    st_nxt = st_r;
    diversity = st_r.mode[MODE_DIVERSITY];
    unique_b = st_r.scale[SCALE_UNIQUE_B] && diversity;
    taps = CNT_W'(st_r.taps_m1) + CNT_W'(1);
    // Tap count beyond the memory is the configuring party's hazard; it wraps here.
    len = diversity ? CNT_W'({taps, 1'b0}) : taps;
    wlen = len + CNT_W'(len[0]);
    wp_inc = CNT_W'(st_r.wptr) + CNT_W'(1);
    wptr_new = st_r.wptr;
    st_nxt.out.valid = 1'b0;
    st_nxt.rvalid = 1'b0;
    st_nxt.p_valid = 1'b0;
    st_nxt.out_pend = 1'b0;
    trig = 1'b0;

    // Host access to registers and memories.
    coef_we = 1'b0;
    coef_waddr = ctl_req.addr[RAM_AW-1:0];
    coef_wdata = ctl_req.wdata[COEF_W-1:0];
    data_we = 1'b0;
    data_waddr = ctl_req.addr[RAM_AW-1:0];
    data_wdata = ctl_req.wdata;
    host_ram_rd = ctl_req.rd && !st_r.busy && (ctl_req.addr[CTL_AW-1] == 1'b0);
    if (ctl_req.wr) begin
      unique case (ctl_req.addr)
        ADDR_MODE: st_nxt.mode = ctl_req.wdata[7:0];
        ADDR_SCALE: st_nxt.scale = ctl_req.wdata[7:0];
        ADDR_RATIO: st_nxt.final_decimation_ratio = ctl_req.wdata[7:0];
        ADDR_OFFSET: st_nxt.coefficient_start_offset = ctl_req.wdata[7:0];
        ADDR_TAPS: st_nxt.taps_m1 = ctl_req.wdata[7:0];
        default: begin
          coef_we = ctl_req.addr[CTL_AW-1:RAM_AW] == PAGE_COEF;
          data_we = ctl_req.addr[CTL_AW-1:RAM_AW] == PAGE_DATA;
        end
      endcase
    end

    // Sample write into the circular buffer; a sample beats a host data write.
    if (in_valid) begin
      data_we = 1'b1;
      data_waddr = st_r.wptr;
      data_wdata = in_sample;
      wptr_new = (wp_inc >= wlen) ? '0 : wp_inc[RAM_AW-1:0];
      st_nxt.wptr = wptr_new;
    end

    // Decimation: in diversity mode one A/B pair counts as one input.
    // A trigger that meets a busy engine is dropped; the tap budget keeps this
    // from happening in a correctly configured system.
    count_ev = in_valid && (!diversity || in_chan_b);
    if (count_ev) begin
      if (st_r.dec_cnt == st_r.final_decimation_ratio[DEC_W-1:0]) begin
        st_nxt.dec_cnt = '0;
        trig = 1'b1;
      end else begin
        st_nxt.dec_cnt = st_r.dec_cnt + DEC_W'(1);
      end
    end

    // Window start: the oldest of the last len samples, len slots before the next write position.
    base_sum = (CNT_W+1)'(wptr_new) + (CNT_W+1)'(wlen) - (CNT_W+1)'(len);
    if (base_sum >= (CNT_W+1)'(wlen)) begin
      base_sum = base_sum - (CNT_W+1)'(wlen);
    end
    if (trig && !st_r.busy) begin
      st_nxt.busy = 1'b1;
      st_nxt.step = '0;
      st_nxt.base = base_sum[CNT_W-1:0];
    end

    // Tap engine: one read per cycle, oldest sample first.
    // The memories answer one edge after the address, so the product of a step
    // meets the accumulator one cycle after the engine issued that step.
    dsum = (CNT_W+1)'(st_r.base) + (CNT_W+1)'(st_r.step);
    if (dsum >= (CNT_W+1)'(wlen)) begin
      dsum = dsum - (CNT_W+1)'(wlen);
    end
    data_raddr = dsum[RAM_AW-1:0];
    if (!diversity || unique_b) begin
      coef_raddr = st_r.coefficient_start_offset + st_r.step[RAM_AW-1:0];
    end else begin
      coef_raddr = st_r.coefficient_start_offset + st_r.step[RAM_AW:1];
    end
    if (host_ram_rd) begin
      data_raddr = ctl_req.addr[RAM_AW-1:0];
      coef_raddr = ctl_req.addr[RAM_AW-1:0];
    end
    if (st_r.busy) begin
      st_nxt.p_valid = 1'b1;
      st_nxt.p_ch = diversity && st_r.step[0];
      st_nxt.p_first = diversity ? (st_r.step < CNT_W'(2)) : (st_r.step == '0);
      st_nxt.p_last = st_r.step == len - CNT_W'(1);
      st_nxt.step = st_r.step + CNT_W'(1);
      if (st_r.step == len - CNT_W'(1)) begin
        st_nxt.busy = 1'b0;
      end
    end

    // Multiply-accumulate: one I and one Q product share the coefficient.
    prod_i = data_q.i * $signed(coef_q);
    prod_q = data_q.q * $signed(coef_q);
    add_i = st_r.p_ch ? st_r.acc_bi : st_r.acc_ai;
    add_q = st_r.p_ch ? st_r.acc_bq : st_r.acc_aq;
    if (st_r.p_first) begin
      add_i = '0;
      add_q = '0;
    end
    add_i = add_i + ACC_W'(prod_i);
    add_q = add_q + ACC_W'(prod_q);
    if (st_r.p_valid) begin
      if (st_r.p_ch) begin
        st_nxt.acc_bi = add_i;
        st_nxt.acc_bq = add_q;
      end else begin
        st_nxt.acc_ai = add_i;
        st_nxt.acc_aq = add_q;
      end
      st_nxt.out_pend = st_r.p_last;
    end

    // Output: A result first, then B one cycle later in diversity mode.
    // The B result waits in its own accumulator, so no extra buffer is needed.
    sc_in_i = st_r.b_pend ? st_r.acc_bi[ACC_W-1:RES_LSB] : st_r.acc_ai[ACC_W-1:RES_LSB];
    sc_in_q = st_r.b_pend ? st_r.acc_bq[ACC_W-1:RES_LSB] : st_r.acc_aq[ACC_W-1:RES_LSB];
    if (st_r.out_pend || st_r.b_pend) begin
      st_nxt.out.valid = 1'b1;
      st_nxt.out.chan_b = st_r.b_pend;
      st_nxt.out.i = sc_out_i;
      st_nxt.out.q = sc_out_q;
      st_nxt.b_pend = st_r.out_pend && diversity;
    end

    // Host reads answer two edges after the request.
    // Registers return their field in the low byte; unmapped addresses read zero.
    st_nxt.rd_pend = ctl_req.rd;
    st_nxt.rd_addr = ctl_req.addr;
    if (st_r.rd_pend) begin
      st_nxt.rvalid = 1'b1;
      unique case (st_r.rd_addr)
        ADDR_MODE: st_nxt.rdata = CTL_DW'(st_r.mode);
        ADDR_SCALE: st_nxt.rdata = CTL_DW'(st_r.scale);
        ADDR_RATIO: st_nxt.rdata = CTL_DW'(st_r.final_decimation_ratio);
        ADDR_OFFSET: st_nxt.rdata = CTL_DW'(st_r.coefficient_start_offset);
        ADDR_TAPS: st_nxt.rdata = CTL_DW'(st_r.taps_m1);
        default: begin
          if (st_r.rd_addr[CTL_AW-1:RAM_AW] == PAGE_COEF) begin
            st_nxt.rdata = CTL_DW'(coef_q);
          end else if (st_r.rd_addr[CTL_AW-1:RAM_AW] == PAGE_DATA) begin
            st_nxt.rdata = data_q;
          end else begin
            st_nxt.rdata = '0;
          end
        end
      endcase
    end

    // Soft reset holds the engine idle and rewinds the buffer while set.
    // Configuration stays intact, so software can reload the memories meanwhile.
    if (st_r.mode[MODE_SOFT_RESET]) begin
      st_nxt.wptr = '0;
      st_nxt.dec_cnt = '0;
      st_nxt.busy = 1'b0;
      st_nxt.p_valid = 1'b0;
      st_nxt.out_pend = 1'b0;
      st_nxt.b_pend = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.mode <= MODE_RESET;
      st_r.scale <= SCALE_RESET;
      st_r.final_decimation_ratio <= RATIO_RESET;
      st_r.coefficient_start_offset <= OFFSET_RESET;
      st_r.taps_m1 <= TAPS_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs, all taken straight from the state register.
  assign out = st_r.out;
  assign ctl_rdata = st_r.rdata;
  assign ctl_rvalid = st_r.rvalid;
  assign engine_busy = st_r.busy;
endmodule

//--- test/rcf_fir_props.sv
// Port-level concurrent checks for the decimating filter.
module rcf_fir_props
  import rcf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic in_chan_b,
  input wire rcf_pkg::rcf_sample_t in_sample,
  input wire rcf_pkg::rcf_ctl_req_t ctl_req,
  input wire logic wide_word,
  input wire logic [rcf_pkg::CTL_DW-1:0] ctl_rdata,
  input wire logic ctl_rvalid,
  input wire logic engine_busy,
  input wire rcf_pkg::rcf_out_t out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  a_busy_cause: assert property ($rose(engine_busy) |-> $past(in_valid))
    else $error("engine started without a sample");
  a_out_after_busy: assert property ($fell(engine_busy) |->
    ##2 (out.valid && !out.chan_b))
    else $error("no A output two cycles after the taps");
  a_out_needs_busy: assert property (out.valid && !out.chan_b |->
    $past(engine_busy, 3) && !$past(engine_busy, 2))
    else $error("A output not tied to the end of the taps");
  a_b_after_a: assert property (out.valid && out.chan_b |->
    $past(out.valid) && !$past(out.chan_b))
    else $error("B output without a preceding A output");
  a_b_single: assert property (out.valid && out.chan_b |=> !out.valid)
    else $error("valid held after the B output");
  // Reset cancels a read in flight, so an answer is not expected right after it.
  a_read_latency: assert property (ctl_rvalid ==
    ($past(ctl_req.rd, 2) && !$past(rst, 2) && !$past(rst)))
    else $error("read answer not two cycles after the request");
  a_narrow_word: assert property (out.valid && !wide_word |->
    out.i[23:15] == {9{out.i[15]}} && out.q[23:15] == {9{out.q[15]}})
    else $error("narrow output word not sign extended from 16 bits");
  a_out_holds: assert property (!out.valid |-> $stable({out.chan_b, out.i, out.q}))
    else $error("output data changed without valid");
endmodule

bind rcf_fir rcf_fir_props u_props (.core_clk(core_clk), .rst(rst), .in_valid(in_valid),
  .in_chan_b(in_chan_b), .in_sample(in_sample), .ctl_req(ctl_req), .wide_word(wide_word),
  .ctl_rdata(ctl_rdata), .ctl_rvalid(ctl_rvalid), .engine_busy(engine_busy), .out(out));

//--- test/rcf_src.sv
// Behavioural upstream decimator stage that sends queued samples at a set spacing.
module rcf_src
  import rcf_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [15:0] gap,
  output logic in_valid,
  output logic in_chan_b,
  output rcf_pkg::rcf_sample_t in_sample,
  output logic idle
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [36:0] fifo[$];
  int wait_n = 0;

  initial begin
    in_valid = 1'b0;
    in_chan_b = 1'b0;
    in_sample = '0;
    idle = 1'b1;
  end

  task automatic push(input logic b, input rcf_sample_t s);
    fifo.push_back({b, s});
    idle = 1'b0;
  endtask

  // ==========================================================================
  // Sample strobe
  always @(posedge core_clk) begin
    #2;
    if (rst) begin
      in_valid = 1'b0;
      wait_n = 0;
    end else if (in_valid) begin
      // Released data flips, so a late capture cannot pass by luck.
      in_valid = 1'b0;
      in_sample = ~in_sample;
      wait_n = int'(gap);
    end else if (wait_n != 0) begin
      wait_n--;
    end else if (fifo.size() != 0) begin
      {in_chan_b, in_sample} = fifo.pop_front();
      in_valid = 1'b1;
    end
    idle = !in_valid && wait_n == 0 && fifo.size() == 0;
  end
endmodule

//--- test/rcf_fir_bench.sv
// Self-checking bench for the decimating filter with a queue-based reference model.
module rcf_fir_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import rcf_pkg::*;

  typedef struct {int t; int b; int i; int q;} rcf_exp_t;

  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic wide_word = 1'b0;
  logic in_valid, in_chan_b, src_idle, ctl_rvalid, engine_busy;
  logic [15:0] gap = 16'h0004;
  logic [CTL_DW-1:0] ctl_rdata, rdat, v36;
  logic [7:0] v;
  logic [9:0] reg_addr[8] = '{10'h300, 10'h309, 10'h30a, 10'h30b, 10'h30c,
    10'h200, 10'h305, 10'h3ff};
  rcf_sample_t in_sample;
  rcf_ctl_req_t ctl_req = '0;
  rcf_out_t out;
  rcf_exp_t e;
  rcf_exp_t exp_q[$];
  int hist_i[$], hist_q[$], coef[256];
  int errors = 0, tests_run = 0, seed = 32'hddee, cyc = 0;
  int taps = 1, ratio = 1, off = 0, scl = 4, div = 0, uniq = 0, cnt = 0;

  always #12.5 core_clk = ~core_clk;

  rcf_fir u_dut (.core_clk(core_clk), .rst(rst), .in_valid(in_valid), .in_chan_b(in_chan_b),
    .in_sample(in_sample), .ctl_req(ctl_req), .wide_word(wide_word), .ctl_rdata(ctl_rdata),
    .ctl_rvalid(ctl_rvalid), .engine_busy(engine_busy), .out(out));
  rcf_src u_src (.core_clk(core_clk), .rst(rst), .gap(gap), .in_valid(in_valid),
    .in_chan_b(in_chan_b), .in_sample(in_sample), .idle(src_idle));

  // ==========================================================================
  // Helpers
  task automatic stop_test();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] want);
    tests_run++;
    if (seen !== want) begin
      errors++;
      $display("[ERR] %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wr(input logic [9:0] a, input logic [35:0] d);
    @(posedge core_clk);
    #2 ctl_req = '{a, 1'b1, 1'b0, d};
    @(posedge core_clk);
    #2 ctl_req.wr = 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, output logic [35:0] d);
    @(posedge core_clk);
    #2 ctl_req = '{a, 1'b0, 1'b1, 36'h0};
    @(posedge core_clk);
    #2 ctl_req.rd = 1'b0;
    @(posedge core_clk);
    #2 check(48'(ctl_rvalid), 48'h1);
    d = ctl_rdata;
  endtask

  // The accumulator wraps at 41 bits; the result is its top 23 bits.
  function automatic int word(input longint a);
    int r;
    r = int'((a <<< 23) >>> 41);
    if (wide_word) return r;
    r = (((r * 16) >>> scl) + 64) >>> 7;
    return r > 32767 ? 32767 : (r < -32768 ? -32768 : r);
  endfunction

  task automatic predict();
    longint ai[2], aq[2];
    int len, base, ch, k;
    ai = '{0, 0};
    aq = '{0, 0};
    len = taps * (div + 1);
    base = hist_i.size() - len;
    for (int s = 0; s < len; s++) begin
      ch = div ? s % 2 : 0;
      k = (div && !uniq) ? off + s / 2 : off + s;
      ai[ch] += longint'(hist_i[base + s]) * coef[k];
      aq[ch] += longint'(hist_q[base + s]) * coef[k];
    end
    exp_q.push_back('{cyc + len + 3, 0, word(ai[0]), word(aq[0])});
    if (div) exp_q.push_back('{cyc + len + 4, 1, word(ai[1]), word(aq[1])});
  endtask

  // ==========================================================================
  // Reference model
  always @(posedge core_clk) begin
    if (!rst && in_valid) begin
      hist_i.push_back(int'(in_sample.i));
      hist_q.push_back(int'(in_sample.q));
      if (!div || in_chan_b) cnt++;
      if (cnt == ratio) begin
        cnt = 0;
        predict();
      end
    end
    if (!rst && out.valid) begin
      check(48'(exp_q.size() != 0), 48'h1);
      if (exp_q.size() != 0) begin
        e = exp_q.pop_front();
        check({out.i, out.q}, {24'(e.i), 24'(e.q)});
        check(48'(out.chan_b), 48'(e.b));
        check(48'(cyc), 48'(e.t));
      end
    end
    cyc++;
  end

  // Soft reset is held while the window is cleared, so the pointer restarts at the base.
  task automatic go(input int t, m, o, s, d, u, w);
    int n;
    n = t * (d + 1) + (t * (d + 1)) % 2;
    wr(ADDR_MODE, 36'(1 + 2 * d));
    taps = t; ratio = m; off = o; scl = s; div = d; uniq = u; cnt = 0;
    wide_word = w[0];
    wr(ADDR_SCALE, 36'(s + 8 * u));
    wr(ADDR_RATIO, 36'(m - 1));
    wr(ADDR_OFFSET, 36'(o));
    wr(ADDR_TAPS, 36'(t - 1));
    for (int k = 0; k < n; k++) wr(10'(256 + k), 36'h0);
    for (int k = o; k < o + t * (u + 1); k++) begin
      coef[k] = $random(seed) >>> 12;
      wr(10'(k), 36'(coef[k] & 32'hfffff));
    end
    wr(ADDR_MODE, 36'(2 * d));
    hist_i = {};
    hist_q = {};
    repeat (n) begin
      hist_i.push_back(0);
      hist_q.push_back(0);
    end
    gap = 16'(t * (d + 1) + 4);
    for (int k = 0; k < 3 * m * (d + 1); k++)
      u_src.push(1'(k % 2 * d), {18'($random(seed)), 18'($random(seed))});
    n = 0;
    while ((src_idle !== 1'b1 || exp_q.size() != 0) && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    check(48'(n < 20000), 48'h1);
    check(48'(exp_q.size()), 48'h0);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    #2 rst = 1'b0;
    foreach (reg_addr[k]) begin
      rd(reg_addr[k], rdat);
      check(48'(rdat[7:0]), k == 1 ? 48'h4 : 48'h0);
      v = 8'($random(seed));
      wr(reg_addr[k], 36'(v));
      rd(reg_addr[k], rdat);
      check(48'(rdat[7:0]), k < 5 ? 48'(v) : 48'h0);
    end
    v36 = 36'({$random(seed), $random(seed)});
    wr(10'h1ff, v36);
    rd(10'h1ff, rdat);
    check(48'(rdat), 48'(v36));
    wr(10'h0ff, v36);
    rd(10'h0ff, rdat);
    check(48'(rdat[19:0]), 48'(v36[19:0]));
    go(1, 1, 0, 4, 0, 0, 0);
    go(5, 3, 10, 2, 0, 0, 0);
    go(8, 32, 0, 7, 0, 0, 0);
    go(6, 2, 3, 0, 0, 0, 1);
    go(3, 2, 20, 6, 1, 0, 0);
    go(3, 1, 6, 5, 1, 1, 0);
    go(4, 4, 252, 3, 0, 0, 0);
    go(2, 5, 100, 1, 0, 0, 0);
    go(256, 1, 0, 0, 0, 0, 0);
    stop_test();
  end

  initial begin
    #1000000;
    errors++;
    stop_test();
  end
endmodule
